//--- core/lpc_config_bank.v
// Link port configuration bank: four byte registers and the controls they drive.
// Assumes the serial management pins and analog status are synchronous to clk.
`default_nettype none
`include "lpc_regs.vh"

module lpc_config_bank #(
    parameter integer PorCalCycles = `LPC_POR_CAL_CYCLES
) (
    input  wire                    clk,
    input  wire                    rst,
    input  wire                    sclIn,
    input  wire                    sdaIn,
    output wire                    sdaOut,
    output wire                    sdaOeN,
    input  wire [1:0]              selChannel,
    input  wire [3:0]              rawClkActivity,
    output reg  [3:0]              chanActive,
    output reg  [3:0]              clkTermEn,
    output reg  [3:0]              dataTermEn,
    output reg  [3:0]              clkTerm100,
    output reg  [3:0]              dataTerm100,
    output reg                     detectEn,
    output reg                     detectCommonMode,
    output reg                     clkHystEn,
    output reg                     clkHyst20mV,
    output wire                    dataHystEn,
    output wire                    termCalActive,
    output wire                    porCalDone,
    output reg                     clkOutOeN,
    output reg                     dataOutOeN,
    output reg  [3:0]              dataCurrentCode,
    output reg  [3:0]              preEmphCode,
    output wire [3:0]              clkCurrentCode,
    input  wire [`LPC_LANE_W-1:0]  laneZeroIn,
    input  wire [`LPC_LANE_W-1:0]  laneOneIn,
    input  wire [`LPC_LANE_W-1:0]  laneTwoIn,
    output reg  [`LPC_LANE_W-1:0]  outputLaneZero,
    output reg  [`LPC_LANE_W-1:0]  outputLaneOne,
    output reg  [`LPC_LANE_W-1:0]  outputLaneTwo
);

    reg  [7:0] inputCtrl_q;
    reg  [7:0] termSelect_q;
    reg  [7:0] outputOptions_q;
    reg  [7:0] dataDrive_q;
    reg  [7:0] rdData;
    wire       wrEn;
    wire [7:0] wrAddr;
    wire [7:0] wrData;
    wire [7:0] rdAddr;
    wire [3:0] selOneHot;

    lpc_mgmt_slave uSlave (
        .clk    (clk),
        .rst    (rst),
        .sclIn  (sclIn),
        .sdaIn  (sdaIn),
        .sdaOut (sdaOut),
        .sdaOeN (sdaOeN),
        .wrEn   (wrEn),
        .wrAddr (wrAddr),
        .wrData (wrData),
        .rdAddr (rdAddr),
        .rdData (rdData)
    );

    lpc_term_cal #(
        .PorCalCycles (PorCalCycles)
    ) uCal (
        .clk        (clk),
        .rst        (rst),
        .recalReq   (inputCtrl_q[`LPC_IC_RECAL]),
        .calActive  (termCalActive),
        .porCalDone (porCalDone)
    );

    // Register writes; unmapped offsets are ignored.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            inputCtrl_q     <= `LPC_RST_INPUT_CTRL;
            termSelect_q    <= `LPC_RST_TERM_SELECT;
            outputOptions_q <= `LPC_RST_OUTPUT_OPTIONS;
            dataDrive_q     <= `LPC_RST_DATA_DRIVE;
        end else if (wrEn) begin
            case (wrAddr)
                `LPC_OFS_INPUT_CTRL:     inputCtrl_q     <= wrData;
                `LPC_OFS_TERM_SELECT:    termSelect_q    <= wrData;
                `LPC_OFS_OUTPUT_OPTIONS: outputOptions_q <= wrData;
                `LPC_OFS_DATA_DRIVE:     dataDrive_q     <= wrData;
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped offsets read as zero.
    always @* begin
        case (rdAddr)
            `LPC_OFS_INPUT_CTRL:     rdData = inputCtrl_q;
            `LPC_OFS_TERM_SELECT:    rdData = termSelect_q;
            `LPC_OFS_OUTPUT_OPTIONS: rdData = outputOptions_q;
            `LPC_OFS_DATA_DRIVE:     rdData = dataDrive_q;
            default:                 rdData = 8'h00;
        endcase
    end

    // Per-channel input termination and activity status.
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1) begin : gChan
            assign selOneHot[ch] = (selChannel == ch);
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    clkTermEn[ch]   <= 1'b1;
                    dataTermEn[ch]  <= 1'b1;
                    clkTerm100[ch]  <= 1'b0;
                    dataTerm100[ch] <= 1'b0;
                    chanActive[ch]  <= 1'b0;
                end else begin
                    if (selOneHot[ch]) begin
                        clkTermEn[ch]  <= ~inputCtrl_q[`LPC_IC_TRI_SEL_CLK];
                        dataTermEn[ch] <= ~inputCtrl_q[`LPC_IC_TRI_SEL_DATA];
                    end else begin
                        clkTermEn[ch]  <= ~inputCtrl_q[`LPC_IC_TRI_UNSEL_CLK];
                        dataTermEn[ch] <= ~inputCtrl_q[`LPC_IC_TRI_UNSEL_DATA];
                    end
                    dataTerm100[ch] <= termSelect_q[`LPC_TS_DATA_LSB + ch];
                    clkTerm100[ch]  <= termSelect_q[`LPC_TS_CLK_LSB + ch];
                    chanActive[ch]  <= rawClkActivity[ch] & ~inputCtrl_q[`LPC_IC_TRI_UNSEL_CLK];
                end
            end
        end
    endgenerate

    // Receiver detection, hysteresis, output enable and drive current controls.
    assign dataHystEn     = 1'b0;
    assign clkCurrentCode = `LPC_CLK_CURRENT_CODE;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            detectEn         <= 1'b1;
            detectCommonMode <= 1'b1;
            clkHystEn        <= 1'b0;
            clkHyst20mV      <= 1'b0;
            clkOutOeN        <= 1'b0;
            dataOutOeN       <= 1'b0;
            dataCurrentCode  <= 4'h0;
            preEmphCode      <= 4'h0;
        end else begin
            detectEn         <= ~inputCtrl_q[`LPC_IC_TRI_UNSEL_CLK];
            detectCommonMode <= inputCtrl_q[`LPC_IC_DETECT_CM];
            clkHystEn        <= inputCtrl_q[`LPC_IC_CLK_HYST_EN];
            clkHyst20mV      <= inputCtrl_q[`LPC_IC_CLK_HYST_20MV];
            clkOutOeN        <= outputOptions_q[`LPC_OO_TRI_CLK];
            dataOutOeN       <= outputOptions_q[`LPC_OO_TRI_DATA];
            dataCurrentCode  <= dataDrive_q[`LPC_DD_CURRENT_LSB +: 4];
            preEmphCode      <= dataDrive_q[`LPC_DD_PREEMPH_LSB +: 4];
        end
    end

    // Output lane routing with optional swap and polarity inversion.
    wire [`LPC_LANE_W-1:0] invMask = {`LPC_LANE_W{outputOptions_q[`LPC_OO_INVERT]}};
    wire                   swapLanes = outputOptions_q[`LPC_OO_SWAP_LANES];

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            outputLaneZero <= {`LPC_LANE_W{1'b0}};
            outputLaneOne  <= {`LPC_LANE_W{1'b0}};
            outputLaneTwo  <= {`LPC_LANE_W{1'b0}};
        end else begin
            outputLaneZero <= (swapLanes ? laneTwoIn : laneZeroIn) ^ invMask;
            outputLaneOne  <= laneOneIn ^ invMask;
            outputLaneTwo  <= (swapLanes ? laneZeroIn : laneTwoIn) ^ invMask;
        end
    end

endmodule // lpc_config_bank
`default_nettype wire

//--- core/lpc_mgmt_slave.v
// Serial management port slave: byte pointer, auto-increment writes and reads.
// Assumes clock and data pins sampled synchronously and an open-drain data line.
`default_nettype none
`include "lpc_regs.vh"

module lpc_mgmt_slave (
    input  wire       clk,
    input  wire       rst,
    input  wire       sclIn,
    input  wire       sdaIn,
    output wire       sdaOut,
    output wire       sdaOeN,
    output reg        wrEn,
    output reg  [7:0] wrAddr,
    output reg  [7:0] wrData,
    output wire [7:0] rdAddr,
    input  wire [7:0] rdData
);

    localparam [7:0] S_IDLE    = 8'h01;
    localparam [7:0] S_ADDR    = 8'h02;
    localparam [7:0] S_ADDRACK = 8'h04;
    localparam [7:0] S_RXBYTE  = 8'h08;
    localparam [7:0] S_RXACK   = 8'h10;
    localparam [7:0] S_TXBYTE  = 8'h20;
    localparam [7:0] S_TXACK   = 8'h40;

    reg [7:0] state_q;
    reg       sclPrev_q;
    reg       sdaPrev_q;
    reg [7:0] rxShift_q;
    reg [7:0] txShift_q;
    reg [3:0] bitCnt_q;
    reg [7:0] ptr_q;
    reg       ptrSeen_q;
    reg       readDir_q;
    reg       masterNack_q;
    reg       sdaDrive_q;

    wire sclRise = sclIn & ~sclPrev_q;
    wire sclFall = ~sclIn & sclPrev_q;
    wire startC  = sclIn & sclPrev_q & sdaPrev_q & ~sdaIn;
    wire stopC   = sclIn & sclPrev_q & ~sdaPrev_q & sdaIn;

    assign sdaOut = 1'b0;
    assign sdaOeN = ~sdaDrive_q;
    assign rdAddr = ptr_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q      <= S_IDLE;
            sclPrev_q    <= 1'b1;
            sdaPrev_q    <= 1'b1;
            rxShift_q    <= 8'h00;
            txShift_q    <= 8'h00;
            bitCnt_q     <= 4'h0;
            ptr_q        <= 8'h00;
            ptrSeen_q    <= 1'b0;
            readDir_q    <= 1'b0;
            masterNack_q <= 1'b0;
            sdaDrive_q   <= 1'b0;
            wrEn         <= 1'b0;
            wrAddr       <= 8'h00;
            wrData       <= 8'h00;
        end else begin
            sclPrev_q <= sclIn;
            sdaPrev_q <= sdaIn;
            wrEn      <= 1'b0;
            if (startC) begin
                state_q    <= S_ADDR;
                bitCnt_q   <= 4'h0;
                sdaDrive_q <= 1'b0;
            end else if (stopC) begin
                state_q    <= S_IDLE;
                sdaDrive_q <= 1'b0;
            end else if (sclRise) begin
                if ((state_q == S_ADDR) || (state_q == S_RXBYTE)) begin
                    rxShift_q <= {rxShift_q[6:0], sdaIn};
                    bitCnt_q  <= bitCnt_q + 4'h1;
                end else if (state_q == S_TXACK) begin
                    masterNack_q <= sdaIn;
                end
            end else if (sclFall) begin
                case (state_q)
                    S_ADDR: begin
                        if (bitCnt_q == 4'h8) begin
                            if (rxShift_q[7:1] == `LPC_MGMT_ADDR) begin
                                sdaDrive_q <= 1'b1;
                                readDir_q  <= rxShift_q[0];
                                state_q    <= S_ADDRACK;
                            end else begin
                                state_q <= S_IDLE;
                            end
                        end
                    end
                    S_ADDRACK: begin
                        bitCnt_q <= 4'h0;
                        if (readDir_q) begin
                            txShift_q  <= rdData;
                            sdaDrive_q <= ~rdData[7];
                            state_q    <= S_TXBYTE;
                        end else begin
                            sdaDrive_q <= 1'b0;
                            ptrSeen_q  <= 1'b0;
                            state_q    <= S_RXBYTE;
                        end
                    end
                    S_RXBYTE: begin
                        if (bitCnt_q == 4'h8) begin
                            sdaDrive_q <= 1'b1;
                            state_q    <= S_RXACK;
                            if (!ptrSeen_q) begin
                                ptr_q     <= rxShift_q;
                                ptrSeen_q <= 1'b1;
                            end else begin
                                wrEn   <= 1'b1;
                                wrAddr <= ptr_q;
                                wrData <= rxShift_q;
                                ptr_q  <= ptr_q + 8'h01;
                            end
                        end
                    end
                    S_RXACK: begin
                        sdaDrive_q <= 1'b0;
                        bitCnt_q   <= 4'h0;
                        state_q    <= S_RXBYTE;
                    end
                    S_TXBYTE: begin
                        if (bitCnt_q == 4'h7) begin
                            sdaDrive_q <= 1'b0;
                            ptr_q      <= ptr_q + 8'h01;
                            state_q    <= S_TXACK;
                        end else begin
                            txShift_q  <= {txShift_q[6:0], 1'b0};
                            sdaDrive_q <= ~txShift_q[6];
                            bitCnt_q   <= bitCnt_q + 4'h1;
                        end
                    end
                    S_TXACK: begin
                        if (masterNack_q) begin
                            state_q <= S_IDLE;
                        end else begin
                            txShift_q  <= rdData;
                            sdaDrive_q <= ~rdData[7];
                            bitCnt_q   <= 4'h0;
                            state_q    <= S_TXBYTE;
                        end
                    end
                    default: begin
                        state_q <= S_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // lpc_mgmt_slave
`default_nettype wire

//--- core/lpc_regs.vh
// Constants for the link port configuration bank: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the core design files.
`ifndef LPC_REGS_VH
`define LPC_REGS_VH

// Register offsets on the serial management port.
`define LPC_OFS_INPUT_CTRL      8'h03
`define LPC_OFS_TERM_SELECT     8'h04
`define LPC_OFS_OUTPUT_OPTIONS  8'h05
`define LPC_OFS_DATA_DRIVE      8'h06

// Reset values and the recommended input control value.
`define LPC_RST_INPUT_CTRL      8'h12
`define LPC_RST_TERM_SELECT     8'h00
`define LPC_RST_OUTPUT_OPTIONS  8'h00
`define LPC_RST_DATA_DRIVE      8'h00
`define LPC_RECOMMENDED_INPUT   8'h62

// Input control fields.
`define LPC_IC_TRI_UNSEL_CLK    0
`define LPC_IC_TRI_UNSEL_DATA   1
`define LPC_IC_TRI_SEL_CLK      2
`define LPC_IC_TRI_SEL_DATA     3
`define LPC_IC_DETECT_CM        4
`define LPC_IC_CLK_HYST_EN      5
`define LPC_IC_CLK_HYST_20MV    6
`define LPC_IC_RECAL            7

// Termination select fields.
`define LPC_TS_DATA_LSB         0
`define LPC_TS_CLK_LSB          4

// Output options fields.
`define LPC_OO_TRI_CLK          0
`define LPC_OO_TRI_DATA         1
`define LPC_OO_INVERT           2
`define LPC_OO_SWAP_LANES       3

// Data drive fields and the fixed clock current code.
`define LPC_DD_CURRENT_LSB      0
`define LPC_DD_PREEMPH_LSB      4
`define LPC_CLK_CURRENT_CODE    4'h0

// Management port address, arbitrary value.
`define LPC_MGMT_ADDR           7'h4c

// Lane symbol width.
`define LPC_LANE_W              10

// Timing: clock period and power-on calibration time.
`define LPC_CLK_PERIOD_NS       4
`define LPC_POR_CAL_TIME_NS     1000000
`define LPC_POR_CAL_CYCLES      (`LPC_POR_CAL_TIME_NS / `LPC_CLK_PERIOD_NS)

`endif

//--- core/lpc_term_cal.v
// Termination calibration sequencer: power-on run, then software recalibration.
// Assumes a single clock and an asynchronous active-high reset.
`default_nettype none
`include "lpc_regs.vh"

module lpc_term_cal #(
    parameter integer PorCalCycles = `LPC_POR_CAL_CYCLES
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        recalReq,
    output reg         calActive,
    output reg         porCalDone
);

    reg [19:0] porCount_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            porCount_q <= PorCalCycles[19:0];
            porCalDone <= 1'b0;
            calActive  <= 1'b1;
        end else begin
            if (porCount_q != 20'h0_0000) begin
                porCount_q <= porCount_q - 20'h0_0001;
            end
            porCalDone <= (porCount_q == 20'h0_0000);
            calActive  <= (porCount_q != 20'h0_0000) | recalReq;
        end
    end

endmodule // lpc_term_cal
`default_nettype wire

//--- dv/lpc_config_bank_monitor.sv
// Checker for the link port configuration bank, bound to every instance of the bank.
// Assumes one clock domain and the asynchronous active-high reset of the bank.
`default_nettype none
`include "lpc_regs.vh"

module lpc_config_bank_monitor #(
    parameter integer PorCalCycles = 20
) (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic [1:0]             selChannel,
    input wire logic [3:0]             rawClkActivity,
    input wire logic [3:0]             chanActive,
    input wire logic [3:0]             clkTermEn,
    input wire logic                   detectEn,
    input wire logic                   dataHystEn,
    input wire logic [3:0]             clkCurrentCode,
    input wire logic                   termCalActive,
    input wire logic                   porCalDone,
    input wire logic [`LPC_LANE_W-1:0] laneZeroIn,
    input wire logic [`LPC_LANE_W-1:0] laneOneIn,
    input wire logic [`LPC_LANE_W-1:0] laneTwoIn,
    input wire logic [`LPC_LANE_W-1:0] outputLaneZero,
    input wire logic [`LPC_LANE_W-1:0] outputLaneOne,
    input wire logic [`LPC_LANE_W-1:0] outputLaneTwo
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Counts edges since the last reset release, saturating.
    int unsigned sinceRst_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            sinceRst_q <= 0;
        else if (sinceRst_q < 1000)
            sinceRst_q <= sinceRst_q + 1;
    end

    property p_dataHyst;
        dataHystEn == 1'b0;
    endproperty
    a_dataHyst: assert property (p_dataHyst) else $error("data hysteresis enabled");

    property p_clkCurrent;
        clkCurrentCode == 4'h0;
    endproperty
    a_clkCurrent: assert property (p_clkCurrent) else $error("clock current code not fixed");

    property p_chanActive;
        !$past(rst) |-> chanActive == ($past(rawClkActivity) & {4{detectEn}});
    endproperty
    a_chanActive: assert property (p_chanActive) else $error("channel activity mismatch");

    property p_unselClkTerm;
        !$past(rst) |-> (clkTermEn & ~(4'h1 << $past(selChannel))) == ({4{detectEn}} & ~(4'h1 << $past(selChannel)));
    endproperty
    a_unselClkTerm: assert property (p_unselClkTerm) else $error("unselected clock termination wrong");

    property p_laneOne;
        !$past(rst) |-> outputLaneOne == $past(laneOneIn) || outputLaneOne == ~$past(laneOneIn);
    endproperty
    a_laneOne: assert property (p_laneOne) else $error("lane one not passed through");

    property p_laneSwap;
        !$past(rst) |->
            ((outputLaneZero ^ outputLaneOne) == ($past(laneZeroIn) ^ $past(laneOneIn))
             && (outputLaneTwo ^ outputLaneOne) == ($past(laneTwoIn) ^ $past(laneOneIn)))
            || ((outputLaneZero ^ outputLaneOne) == ($past(laneTwoIn) ^ $past(laneOneIn))
             && (outputLaneTwo ^ outputLaneOne) == ($past(laneZeroIn) ^ $past(laneOneIn)));
    endproperty
    a_laneSwap: assert property (p_laneSwap) else $error("lane zero or two misrouted");

    property p_porCalRun;
        sinceRst_q < PorCalCycles |-> termCalActive && !porCalDone;
    endproperty
    a_porCalRun: assert property (p_porCalRun) else $error("power-on calibration ended early");

    property p_porCalEnd;
        sinceRst_q == PorCalCycles + 4 |-> porCalDone;
    endproperty
    a_porCalEnd: assert property (p_porCalEnd) else $error("power-on calibration never ended");
endmodule // lpc_config_bank_monitor

bind lpc_config_bank lpc_config_bank_monitor #(.PorCalCycles(PorCalCycles)) i_lpc_config_bank_monitor (
    .clk, .rst, .selChannel, .rawClkActivity, .chanActive, .clkTermEn, .detectEn, .dataHystEn,
    .clkCurrentCode, .termCalActive, .porCalDone, .laneZeroIn, .laneOneIn, .laneTwoIn,
    .outputLaneZero, .outputLaneOne, .outputLaneTwo
);
`default_nettype wire

//--- dv/lpc_config_bank_tb.sv
// Self-checking bench for the link port configuration bank over its management port.
// Assumes the core sources and the checker are compiled before this file.
`default_nettype none
`include "lpc_regs.vh"
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin errorCnt++; $display("unexpected %0s exp %h got %h", nm, e, g); end end

module lpc_config_bank_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int Cal = 20;

    logic        clk;
    logic        rst;
    logic        sclM;
    logic        sdaM;
    wire         sdaLine;
    wire         sdaOut;
    wire         sdaOeN;
    wire         porDone;
    logic [1:0]  sel;
    logic [3:0]  raw;
    logic [9:0]  l0;
    logic [9:0]  l1;
    logic [9:0]  l2;
    wire  [39:0] cfgOut;
    wire  [29:0] laneOut;
    logic [7:0]  shadow [3:6];
    logic [63:0] expQ [$];
    logic [63:0] gotQ [$];
    string       nameQ [$];
    event        gotEv;
    int          errorCnt;
    int          checksDone;
    integer      seed;

    // The device only ever pulls the open-drain data line low.
    assign sdaLine = sdaM & (sdaOeN | sdaOut);

    lpc_config_bank #(.PorCalCycles(Cal)) i_lpc_config_bank (
        .clk(clk), .rst(rst), .sclIn(sclM), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
        .selChannel(sel), .rawClkActivity(raw), .chanActive(cfgOut[39:36]), .clkTermEn(cfgOut[35:32]),
        .dataTermEn(cfgOut[31:28]), .clkTerm100(cfgOut[27:24]), .dataTerm100(cfgOut[23:20]),
        .detectEn(cfgOut[19]), .detectCommonMode(cfgOut[18]), .clkHystEn(cfgOut[17]),
        .clkHyst20mV(cfgOut[16]), .dataHystEn(cfgOut[15]), .termCalActive(cfgOut[14]), .porCalDone(porDone),
        .clkOutOeN(cfgOut[13]), .dataOutOeN(cfgOut[12]), .dataCurrentCode(cfgOut[11:8]),
        .preEmphCode(cfgOut[7:4]), .clkCurrentCode(cfgOut[3:0]), .laneZeroIn(l0), .laneOneIn(l1),
        .laneTwoIn(l2), .outputLaneZero(laneOut[29:20]), .outputLaneOne(laneOut[19:10]),
        .outputLaneTwo(laneOut[9:0])
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic endOfTest();
        @(negedge clk);
        $display("checks %0d errors %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Records the expected value and hands the observed one to the comparing process.
    task automatic note(input logic [63:0] e, input logic [63:0] g, input string nm);
        expQ.push_back(e);
        gotQ.push_back(g);
        nameQ.push_back(nm);
        -> gotEv;
    endtask

    // Drains every pending note, so notes taken in one time step are never lost.
    initial begin : compare
        logic [63:0] e;
        logic [63:0] g;
        string       nm;
        forever begin
            @(gotEv);
            while (expQ.size() != 0) begin
                e = expQ.pop_front();
                g = gotQ.pop_front();
                nm = nameQ.pop_front();
                `CHK(nm, e, g)
            end
        end
    end

    task automatic hp();
        repeat (3) @(negedge clk);
    endtask

    task automatic start();
        sdaM = 1'b1;
        hp();
        sclM = 1'b1;
        hp();
        sdaM = 1'b0;
        hp();
        sclM = 1'b0;
        @(negedge clk);
    endtask

    task automatic stop();
        sdaM = 1'b0;
        hp();
        sclM = 1'b1;
        hp();
        sdaM = 1'b1;
        hp();
    endtask

    // Nine bit slots, most significant first; the last slot is the acknowledge.
    task automatic bits(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sdaM = tx[i];
            hp();
            sclM = 1'b1;
            hp();
            rx[i] = sdaLine;
            sclM = 1'b0;
            @(negedge clk);
        end
    endtask

    task automatic sendByte(input logic [7:0] b, input logic ackLvl);
        logic [8:0] rx;
        bits({b, 1'b1}, rx);
        note({63'h0, ackLvl}, {63'h0, rx[0]}, "ack");
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        logic [8:0] rx;
        start();
        sendByte({`LPC_MGMT_ADDR, 1'b0}, 1'b0);
        sendByte(ofs, 1'b0);
        bits({d, 1'b1}, rx);
        stop();
        if (ofs >= 8'h03 && ofs <= 8'h06)
            shadow[ofs] = d;
    endtask

    task automatic rd(input logic [7:0] ofs);
        logic [8:0] rx;
        start();
        sendByte({`LPC_MGMT_ADDR, 1'b0}, 1'b0);
        sendByte(ofs, 1'b0);
        start();
        sendByte({`LPC_MGMT_ADDR, 1'b1}, 1'b0);
        bits(9'h1ff, rx);
        stop();
        note({56'h0, (ofs >= 8'h03 && ofs <= 8'h06) ? shadow[ofs] : 8'h00}, {56'h0, rx[8:1]}, "readBack");
    endtask

    function automatic logic [39:0] expCfg();
        logic [7:0] r3;
        logic [3:0] sm;
        r3 = shadow[3];
        sm = 4'h1 << sel;
        return {raw & {4{~r3[0]}},
                (sm & {4{~r3[2]}}) | (~sm & {4{~r3[0]}}),
                (sm & {4{~r3[3]}}) | (~sm & {4{~r3[1]}}),
                shadow[4][7:4], shadow[4][3:0],
                ~r3[0], r3[4], r3[5], r3[6], 1'b0, r3[7],
                shadow[5][0], shadow[5][1], shadow[6][3:0], shadow[6][7:4], 4'h0};
    endfunction

    function automatic logic [29:0] expLane();
        logic [9:0] inv;
        inv = {10{shadow[5][2]}};
        return shadow[5][3] ? {l2 ^ inv, l1 ^ inv, l0 ^ inv} : {l0 ^ inv, l1 ^ inv, l2 ^ inv};
    endfunction

    task automatic checkOuts();
        repeat (2) @(negedge clk);
        note({24'h0, expCfg()}, {24'h0, cfgOut}, "cfgOut");
        note({34'h0, expLane()}, {34'h0, laneOut}, "laneOut");
    endtask

    initial begin : main
        logic [7:0] ofs;
        seed = 48106;
        rst = 1'b1;
        sclM = 1'b1;
        sdaM = 1'b1;
        sel = 2'h0;
        raw = 4'h0;
        l0 = 10'h0;
        l1 = 10'h0;
        l2 = 10'h0;
        shadow[3] = `LPC_RST_INPUT_CTRL;
        for (int a = 4; a <= 6; a++)
            shadow[a] = 8'h00;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        note(64'h1, {63'h0, cfgOut[14]}, "calActive");
        for (int i = 0; i < 100 && porDone !== 1'b1; i++)
            @(negedge clk);
        if (porDone !== 1'b1) begin
            errorCnt++;
            $display("unexpected porCalDone exp 1 got %b", porDone);
            endOfTest();
        end
        checkOuts();
        for (int a = 3; a <= 6; a++)
            rd(8'(a));
        wr(8'h03, `LPC_RECOMMENDED_INPUT);
        rd(8'h03);
        checkOuts();
        wr(8'h03, 8'he2);
        checkOuts();
        wr(8'h03, 8'h62);
        start();
        sendByte({`LPC_MGMT_ADDR ^ 7'h01, 1'b0}, 1'b1);
        stop();
        for (int i = 0; i < 24; i++) begin
            ofs = 8'h02 + 8'($unsigned($random(seed)) % 6);
            sel = 2'($random(seed));
            raw = 4'($random(seed));
            l0 = 10'($random(seed));
            l1 = 10'($random(seed));
            l2 = 10'($random(seed));
            wr(ofs, 8'($random(seed)));
            rd(ofs);
            checkOuts();
        end
        endOfTest();
    end
endmodule // lpc_config_bank_tb
`default_nettype wire
